// *** rtl/sadc_consts.svh ***
/*
  Constants of the converter control and readout block: widths, pin bit
  positions, synchroniser layout and conversion timing.
  Assumes a 250 MHz system clock and inclusion by its bare name.
*/
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

`define SADC_RES_W 16
`define SADC_HALF_W 8
`define SADC_MSB 15
`define SADC_MSB_MASK 16'h8000
`define SADC_ZERO_WORD 16'h0000

`define SADC_CONV_TIME_NS 1300
`define SADC_SYS_CLK_MHZ 250
`define SADC_NS_PER_US 1000
// Longest time per step: rounded down so the whole conversion fits
`define SADC_STEP_CYCLES ((`SADC_CONV_TIME_NS * `SADC_SYS_CLK_MHZ / `SADC_NS_PER_US) / `SADC_RES_W)
`define SADC_TMR_W 5
`define SADC_IDX_W 4

`define SADC_SER_CNT_W 5
`define SADC_CHAIN_SERIAL_IN_BIT 9
`define SADC_SERIAL_RESULT_OUT_BIT 10
`define SADC_SCLK_BIT 11

`define SADC_BUF_DEPTH 2

`define SADC_SYNC_W 8
`define SADC_SYNC_RST 8'hE0
`define SADC_SY_CNV 7
`define SADC_SY_CS 6
`define SADC_SY_RD 5
`define SADC_SY_SEL 4
`define SADC_SY_OB 3
`define SADC_SY_SWAP 2
`define SADC_SY_PD 1
`define SADC_SY_CMP 0

`endif

// *** rtl/sadc_pkg.sv ***
/*
  Types shared by the converter control files.
  Assumes sadc_consts.svh is on the include path.
*/
`include "sadc_consts.svh"

package sadc_pkg;

  typedef logic [`SADC_RES_W-1:0] sadc_word_t;

  typedef enum logic [2:0]
  {
    sadc_st_idle = 3'h1,
    sadc_st_step = 3'h2,
    sadc_st_done = 3'h4
  } sadc_seq_state_t;

endpackage

// *** rtl/sadc_sar_seq.sv ***
/*
  Successive-approximation sequencer: resolves one bit per timed step,
  MSB first, and offers the finished word with valid and ready.
  Assumes a comparator level already synchronised to sys_clk.
*/
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_sar_seq
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic comp_keep,
  output sadc_word_t trial,
  output logic running,
  output logic res_valid,
  input wire logic res_ready,
  output sadc_word_t result
);

  sadc_seq_state_t state_q, state_d;
  sadc_word_t trial_q, trial_d;
  logic [`SADC_IDX_W-1:0] idx_q, idx_d;
  logic [`SADC_TMR_W-1:0] tmr_q, tmr_d;

  always_comb
  begin
    state_d = state_q;
    trial_d = trial_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    case (state_q)
      sadc_st_idle:
      begin
        if (start)
        begin
          state_d = sadc_st_step;
          trial_d = `SADC_MSB_MASK;
          idx_d = `SADC_IDX_W'(`SADC_MSB);
          tmr_d = '0;
        end
      end
      sadc_st_step:
      begin
        // Internal step timer stands in for the conversion oscillator
        if (tmr_q == `SADC_TMR_W'(`SADC_STEP_CYCLES - 1))
        begin
          tmr_d = '0;
          if (!comp_keep)
            trial_d[idx_q] = 1'b0;
          if (idx_q == '0)
            state_d = sadc_st_done;
          else
          begin
            idx_d = idx_q - 1'b1;
            trial_d[idx_q - 1'b1] = 1'b1;
          end
        end
        else
          tmr_d = tmr_q + 1'b1;
      end
      sadc_st_done:
      begin
        // Held here while the buffer is full; busy stays high meanwhile
        if (res_ready)
          state_d = sadc_st_idle;
      end
      default:
        state_d = sadc_st_idle;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= sadc_st_idle;
      trial_q <= `SADC_ZERO_WORD;
      idx_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      trial_q <= trial_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
    end
  end

  assign trial = trial_q;
  assign running = (state_q != sadc_st_idle);
  assign res_valid = (state_q == sadc_st_done);
  assign result = trial_q;

endmodule

// *** rtl/sadc_buf2.sv ***
/*
  Two-entry result buffer with valid and ready on both sides.
  Assumes both sides on sys_clk; a stalled reader makes it fill.
*/
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_buf2
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input sadc_word_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output sadc_word_t out_data
);

  sadc_word_t mem_q [`SADC_BUF_DEPTH];
  sadc_word_t mem_d [`SADC_BUF_DEPTH];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'(`SADC_BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop)
      rd_d = ~rd_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_q <= '{default: `SADC_ZERO_WORD};
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** rtl/sadc_top.sv ***
/*
  Conversion control and result readout of a 16-bit SAR converter:
  start detection, SAR sequencing, result holding, parallel bus and
  serial shift port with daisy chaining.
  Assumes pins asynchronous to sys_clk; shift_clk comes from the host and
  may stand still between frames; the analog side supplies a comparator
  level and takes the trial word and the hold signal.
*/
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_top
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic interface_select,
  input wire logic output_coding_select,
  input wire logic byte_order_swap,
  input wire logic power_down_in,
  input wire logic chain_serial_in,
  input wire logic comparator_in,
  output sadc_word_t approximation_dac,
  output logic sample_hold,
  output logic busy,
  output logic serial_result_out,
  output sadc_word_t bus_out,
  output sadc_word_t bus_oe
);

  // ************************************************************
  // Functions
  // ************************************************************

  function automatic sadc_word_t code_word(input sadc_word_t raw, input logic offset_bin);
    sadc_word_t w;
    w = raw;
    if (!offset_bin)
      w[`SADC_MSB] = ~raw[`SADC_MSB];
    return w;
  endfunction

  function automatic sadc_word_t lane_order(input sadc_word_t w, input logic swap);
    sadc_word_t o;
    if (swap)
      o = {w[`SADC_HALF_W-1:0], w[`SADC_RES_W-1:`SADC_HALF_W]};
    else
      o = w;
    return o;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  logic [`SADC_SYNC_W-1:0] pin_raw;
  logic [`SADC_SYNC_W-1:0] meta_q, meta_d;
  logic [`SADC_SYNC_W-1:0] sync_q, sync_d;

  assign pin_raw[`SADC_SY_CNV] = convert_start_n;
  assign pin_raw[`SADC_SY_CS] = chip_select_n;
  assign pin_raw[`SADC_SY_RD] = read_n;
  assign pin_raw[`SADC_SY_SEL] = interface_select;
  assign pin_raw[`SADC_SY_OB] = output_coding_select;
  assign pin_raw[`SADC_SY_SWAP] = byte_order_swap;
  assign pin_raw[`SADC_SY_PD] = power_down_in;
  assign pin_raw[`SADC_SY_CMP] = comparator_in;

  // First stage feeds only the second stage, never logic
  genvar gi;
  generate
    for (gi = 0; gi < `SADC_SYNC_W; gi++)
    begin : g_sync
      always_comb
      begin
        meta_d[gi] = pin_raw[gi];
        sync_d[gi] = meta_q[gi];
      end
    end
  endgenerate

  // No reset here: the stages keep tracking the pins through reset, so the
  // coding and select levels are already true at release and data stays put
  always_ff @(posedge sys_clk)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  logic cnv_s, cs_s, rd_s, sel_s, ob_s, swap_s, pd_s, cmp_s;

  assign cnv_s = sync_q[`SADC_SY_CNV];
  assign cs_s = sync_q[`SADC_SY_CS];
  assign rd_s = sync_q[`SADC_SY_RD];
  assign sel_s = sync_q[`SADC_SY_SEL];
  assign ob_s = sync_q[`SADC_SY_OB];
  assign swap_s = sync_q[`SADC_SY_SWAP];
  assign pd_s = sync_q[`SADC_SY_PD];
  assign cmp_s = sync_q[`SADC_SY_CMP];

  // ************************************************************
  // Conversion start
  // ************************************************************

  logic cnv_prev_q, cnv_prev_d;
  logic busy_q, busy_d;
  logic start_req;
  logic seq_running;

  always_comb
  begin
    cnv_prev_d = cnv_s;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnv_prev_q <= 1'b1;
    else
      cnv_prev_q <= cnv_prev_d;
  end

  // Chip select plays no part here; power down and busy block it
  assign start_req = cnv_prev_q && !cnv_s && !pd_s && !busy_q;

  // ************************************************************
  // Sequencer and result buffer
  // ************************************************************

  sadc_word_t seq_result;
  sadc_word_t buf_data;
  logic seq_valid, seq_ready;
  logic buf_valid, buf_ready;

  sadc_sar_seq u_seq
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(start_req),
    .comp_keep(cmp_s),
    .trial(approximation_dac),
    .running(seq_running),
    .res_valid(seq_valid),
    .res_ready(seq_ready),
    .result(seq_result)
  );

  sadc_buf2 u_buf
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(seq_valid),
    .in_ready(seq_ready),
    .in_data(seq_result),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  assign sample_hold = seq_running;

  // ************************************************************
  // Result holding register and busy
  // ************************************************************

  sadc_word_t hold_q, hold_d;
  logic read_act;

  assign read_act = !cs_s && !rd_s;
  // Draining stalls during any access so a word never changes mid-read
  assign buf_ready = cs_s;

  always_comb
  begin
    hold_d = hold_q;
    if (buf_valid && buf_ready)
      hold_d = buf_data;
    // Busy falls only once the new word sits in the holding register
    busy_d = start_req || seq_running || buf_valid;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_q <= `SADC_ZERO_WORD;
      busy_q <= 1'b0;
    end
    else
    begin
      hold_q <= hold_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;

  // ************************************************************
  // Parallel data and serial frame control
  // ************************************************************

  sadc_word_t par_q, par_d;
  sadc_word_t snap_q, snap_d;
  logic frame_clr_q, frame_clr_d;

  always_comb
  begin
    par_d = lane_order(code_word(hold_q, ob_s), swap_s);
    snap_d = snap_q;
    // Snapshot frozen while chip select is low, so shift domain reads it quasi-static
    if (frame_clr_q)
      snap_d = code_word(hold_q, ob_s);
    frame_clr_d = cs_s;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      par_q <= `SADC_ZERO_WORD;
      snap_q <= `SADC_ZERO_WORD;
      frame_clr_q <= 1'b1;
    end
    else
    begin
      par_q <= par_d;
      snap_q <= snap_d;
      frame_clr_q <= frame_clr_d;
    end
  end

  // ************************************************************
  // Shift clock domain
  // ************************************************************

  logic [`SADC_SER_CNT_W-1:0] sh_cnt_q, sh_cnt_d;
  sadc_word_t sh_reg_q, sh_reg_d;
  logic sh_out_q, sh_out_d;

  always_comb
  begin
    sh_cnt_d = sh_cnt_q;
    sh_reg_d = {sh_reg_q[`SADC_MSB-1:0], chain_serial_in};
    sh_out_d = sh_reg_q[`SADC_MSB];
    if (sh_cnt_q == '0)
    begin
      // First edge of a frame: result MSB goes out at once
      sh_out_d = snap_q[`SADC_MSB];
      sh_reg_d = {snap_q[`SADC_MSB-1:0], chain_serial_in};
    end
    if (sh_cnt_q != `SADC_SER_CNT_W'(`SADC_RES_W))
      sh_cnt_d = sh_cnt_q + 1'b1;
  end

  // Frame end is taken over from the system side, since the host
  // stops the shift clock between frames
  always_ff @(posedge shift_clk or posedge frame_clr_q)
  begin
    if (frame_clr_q)
    begin
      sh_cnt_q <= '0;
      sh_reg_q <= `SADC_ZERO_WORD;
      sh_out_q <= 1'b0;
    end
    else
    begin
      sh_cnt_q <= sh_cnt_d;
      sh_reg_q <= sh_reg_d;
      sh_out_q <= sh_out_d;
    end
  end

  assign serial_result_out = sh_out_q;

  // ************************************************************
  // Bus drivers
  // ************************************************************

  always_comb
  begin
    bus_out = `SADC_ZERO_WORD;
    bus_oe = `SADC_ZERO_WORD;
    if (sel_s)
    begin
      bus_out[`SADC_SERIAL_RESULT_OUT_BIT] = sh_out_q;
      bus_oe[`SADC_SERIAL_RESULT_OUT_BIT] = read_act && !rst;
    end
    else
    begin
      bus_out = par_q;
      bus_oe = {`SADC_RES_W{read_act && !rst}};
    end
  end

endmodule

// *** tb/sadc_host_model.sv ***
/*
  Host side of the serial read port: shift clock and daisy-chain input.
  Assumes the bench holds chip select and read strobe low around a frame.
*/
`timescale 1ns/10ps
module sadc_host_model
(
  output logic shift_clk,
  output logic chain_serial_in,
  input wire logic serial_result_out
);
  // ****
  // Frame
  // ****
  initial
  begin
    shift_clk = 1'b0;
    chain_serial_in = 1'b0;
  end

  // Clock stands low between frames; 64 ns period, phase off sys_clk
  task automatic read_frame(input logic [15:0] chain, output logic [31:0] got);
    integer i;
    begin
      #13;
      for (i = 0; i < 32; i++)
      begin
        chain_serial_in = (i < 16) ? chain[15-i] : ~chain_serial_in;
        #32 shift_clk = 1'b1;
        #32 shift_clk = 1'b0;
        got = {got[30:0], serial_result_out};
      end
      // Released line must not look like held data
      chain_serial_in = ~chain_serial_in;
    end
  endtask
endmodule

// *** tb/sadc_top_sva.sv ***
/*
  Checker of the converter control block ports.
  Assumes a bench that keeps select pins steady while reading.
*/
`timescale 1ns/10ps
module sadc_top_sva
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic interface_select,
  input wire logic output_coding_select,
  input wire logic byte_order_swap,
  input wire logic power_down_in,
  input sadc_word_t approximation_dac,
  input wire logic sample_hold,
  input wire logic busy,
  input sadc_word_t bus_out,
  input sadc_word_t bus_oe
);
  // ****
  // Properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Saturates so a long stall cannot wrap it
  logic [9:0] busy_cnt_q;
  logic [9:0] busy_cnt_d;
  always_comb busy_cnt_d = (rst || !busy) ? 10'h000 :
    (busy_cnt_q == 10'h3FF) ? busy_cnt_q : busy_cnt_q + 10'h001;
  always_ff @(posedge sys_clk) busy_cnt_q <= busy_cnt_d;

  oe_gate_a: assert property (|bus_oe |-> $past(!chip_select_n && !read_n, 2))
    else $error("bus driven without select and read");
  rst_hiz_a: assert property (disable iff (1'b0) rst |-> bus_oe == 16'h0000)
    else $error("bus driven in reset");
  ser_pins_a: assert property (interface_select && $past(interface_select, 3)
    |-> (bus_oe & 16'hFBFF) == 16'h0000)
    else $error("unused pin driven in serial mode");
  par_all_a: assert property (|bus_oe && !interface_select && !$past(interface_select, 3)
    |-> &bus_oe)
    else $error("parallel bus partly driven");
  busy_rise_a: assert property ($rose(busy) |-> sample_hold && approximation_dac == 16'h8000)
    else $error("start without hold or MSB trial");
  conv_len_a: assert property ($fell(busy) |-> busy_cnt_q >= 10'h140)
    else $error("conversion shorter than sixteen steps");
  pd_block_a: assert property (!busy && power_down_in && $past(power_down_in, 4) |=> !busy)
    else $error("conversion started in power down");
  no_restart_a: assert property ($rose(sample_hold) |-> !$past(busy))
    else $error("conversion restarted while busy");
  hold_stable_a: assert property (&bus_oe && $past(&bus_oe)
    && $past(output_coding_select, 3) == output_coding_select
    && $past(byte_order_swap, 3) == byte_order_swap |-> $stable(bus_out))
    else $error("held result changed during read");
endmodule

bind sadc_top sadc_top_sva chk_i (.sys_clk, .rst, .chip_select_n, .read_n, .interface_select,
  .output_coding_select, .byte_order_swap, .power_down_in, .approximation_dac,
  .sample_hold, .busy, .bus_out, .bus_oe);

// *** tb/test_sar_adc_conversion_and_readout.sv ***
/*
  Bench of the converter control block: conversions, parallel and serial
  reads, power down, stalls and reset. Assumes the host model on serial.
*/
`timescale 1ns/10ps
module test_sar_adc_conversion_and_readout
  import sadc_pkg::*;
();
  // ****
  // Harness
  // ****
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic convert_start_n = 1'b1;
  logic chip_select_n = 1'b1;
  logic read_n = 1'b1;
  logic interface_select = 1'b0;
  logic output_coding_select = 1'b1;
  logic byte_order_swap = 1'b0;
  logic power_down_in = 1'b0;
  logic shift_clk;
  logic chain_serial_in;
  logic comparator_in;
  logic sample_hold;
  logic busy;
  logic serial_result_out;
  sadc_word_t target = 16'h0000;
  sadc_word_t dac;
  sadc_word_t bus_out;
  sadc_word_t bus_oe;
  logic [31:0] got;
  int bad_count = 0;
  int comparisons = 0;

  always #2 sys_clk = ~sys_clk;
  // Ideal comparator: keep the trial bit while it does not exceed the input
  assign comparator_in = (dac <= target);

  sadc_top dut (.sys_clk, .rst, .shift_clk, .convert_start_n, .chip_select_n, .read_n,
    .interface_select, .output_coding_select, .byte_order_swap, .power_down_in,
    .chain_serial_in, .comparator_in, .approximation_dac(dac), .sample_hold, .busy,
    .serial_result_out, .bus_out, .bus_oe);
  sadc_host_model p (.shift_clk, .chain_serial_in, .serial_result_out);

  function automatic sadc_word_t coded(input sadc_word_t t, input logic ob);
    return ob ? t : t ^ 16'h8000;
  endfunction

  task automatic give_verdict;
    begin
      $display("Checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input sadc_word_t exp, input sadc_word_t seen);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    for (int n = 0; n < lim && busy !== lvl; n++)
      step(1);
    chk("busy", {15'h0000, lvl}, {15'h0000, busy});
    if (busy !== lvl)
      give_verdict;
  endtask

  task automatic start_conv(input sadc_word_t t);
    target = t;
    convert_start_n = 1'b0;
    step(3);
    convert_start_n = 1'b1;
    wait_busy(1'b1, 10);
  endtask

  task automatic par_read(input sadc_word_t exp);
    chip_select_n = 1'b0;
    read_n = 1'b0;
    step(4);
    chk("bus_oe", 16'hFFFF, bus_oe);
    chk("bus_out", exp, bus_out);
    chip_select_n = 1'b1;
    read_n = 1'b1;
    step(4);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_par;
    sadc_word_t w;
    start_conv(16'h3A5C);
    wait_busy(1'b0, 400);
    for (int i = 0; i < 4; i++)
    begin
      output_coding_select = i[0];
      byte_order_swap = i[1];
      step(4);
      w = coded(16'h3A5C, i[0]);
      par_read(i[1] ? {w[7:0], w[15:8]} : w);
    end
    $display("parallel test done");
  endtask

  task automatic t_ser;
    start_conv(16'hC3A1);
    wait_busy(1'b0, 400);
    interface_select = 1'b1;
    output_coding_select = 1'b0;
    step(4);
    p.read_frame(16'hFFFF, got);
    chk("gated frame", 16'h0000, got[15:0]);
    step(4);
    chip_select_n = 1'b0;
    read_n = 1'b0;
    step(6);
    chk("bus_oe", 16'h0400, bus_oe);
    p.read_frame(16'h5A3C, got);
    chk("serial word", coded(16'hC3A1, 1'b0), got[31:16]);
    chk("chain", 16'h5A3C, got[15:0]);
    step(1);
    chip_select_n = 1'b1;
    read_n = 1'b1;
    interface_select = 1'b0;
    output_coding_select = 1'b1;
    byte_order_swap = 1'b0;
    step(4);
    $display("serial test done");
  endtask

  task automatic t_pd;
    power_down_in = 1'b1;
    step(4);
    convert_start_n = 1'b0;
    step(3);
    convert_start_n = 1'b1;
    step(30);
    chk("busy", 16'h0000, {15'h0000, busy});
    power_down_in = 1'b0;
    step(4);
    $display("power down test done");
  endtask

  task automatic t_ign;
    start_conv(16'h0F0F);
    step(100);
    convert_start_n = 1'b0;
    step(3);
    convert_start_n = 1'b1;
    wait_busy(1'b0, 250);
    par_read(16'h0F0F);
    $display("restart test done");
  endtask

  task automatic t_stall;
    chip_select_n = 1'b0;
    start_conv(16'h7E81);
    step(400);
    chk("busy", 16'h0001, {15'h0000, busy});
    chip_select_n = 1'b1;
    wait_busy(1'b0, 20);
    par_read(16'h7E81);
    $display("stall test done");
  endtask

  task automatic t_rst;
    chip_select_n = 1'b0;
    read_n = 1'b0;
    start_conv(16'h1234);
    step(50);
    rst = 1'b1;
    step(2);
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("bus_oe", 16'h0000, bus_oe);
    chk("sample_hold", 16'h0000, {15'h0000, sample_hold});
    rst = 1'b0;
    step(6);
    chk("bus_out", 16'h0000, bus_out);
    chip_select_n = 1'b1;
    read_n = 1'b1;
    step(4);
    $display("reset test done");
  endtask

  initial
  begin
    step(4);
    rst = 1'b0;
    step(4);
    t_par;
    t_ser;
    t_pd;
    t_ign;
    t_stall;
    t_rst;
    give_verdict;
  end
endmodule
